// ===== fsp_sequencer.sv
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - fuse one fetches zero, zero boot address
// - cpu has no path to change fuses
// - pointer splits into word and page fields
// - target address latched when operation starts
// - lock setting ignores pointer and extended page
// - load instructions select byte by pointer bit0
// - buffer words load in any order
// - erase command then store within four cycles
// - erase of halting section stalls the cpu
// - load command stores data word at word field
// - buffer clears on write, reenable, reset
// - eeprom write discards loaded buffer data
// - write command then store within four cycles
// - write of halting section stalls the cpu
// - interrupt asserted while store enable is clear
// - window expiry clears store enable and lock
// - busy flag set by non-halting section programming, stays until reenable
module fsp_sequencer (
  input wire logic clk,
  input wire logic rst_n,
  input fsp_pkg::fsp_bus_t bus,
  output logic [7:0] rdata,
  input wire logic store_exec,
  input wire logic load_exec,
  input wire logic eeprom_write,
  input wire logic eeprom_busy,
  input wire logic boot_vector_fuse,
  output logic [15:0] reset_vector,
  output logic cpu_halt,
  output logic store_irq,
  output logic flash_erase_req,
  output logic flash_write_req,
  output logic flash_lock_req,
  output logic [fsp_pkg::PAGE_W-1:0] flash_page,
  input wire logic flash_done,
  input wire logic [fsp_pkg::WORD_W-1:0] flash_buf_idx,
  output logic [15:0] flash_buf_word,
  output logic [15:0] flash_read_addr,
  input wire logic [15:0] flash_read_word,
  output logic [7:0] load_data
);
  import fsp_pkg::*;

  typedef struct packed {
    fsp_state_t st;
    fsp_ctrl_t ctrl;
    logic [2:0] win;
    logic [15:0] ptr;
    logic ext;
    logic [7:0] dlo;
    logic [7:0] dhi;
    logic [3:0] lock;
    logic [PAGE_W-1:0] op_page;
    logic op_write;
    logic op_halt;
    logic erase_req;
    logic write_req;
    logic lock_req;
    logic buf_used;
    logic [7:0] rd;
    logic [7:0] ld;
    logic [2:0] fsync;
    logic fuse;
    logic [15:0] vec;
  } fsp_seq_state_t;

  fsp_seq_state_t s_ff;
  fsp_seq_state_t nxt_s;
  logic buf_wr;
  logic buf_clr;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [PAGE_W-1:0] page_of(input logic ext, input logic [15:0] p);
    page_of = {ext, p[15:8]};
  endfunction

  function automatic logic in_halt(input logic [PAGE_W-1:0] pg);
    in_halt = (pg >= HALT_FIRST_PAGE);
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_s = s_ff;
    buf_wr = 1'b0;
    buf_clr = 1'b0;
    nxt_s.erase_req = 1'b0;
    nxt_s.write_req = 1'b0;
    nxt_s.lock_req = 1'b0;
    nxt_s.rd = 8'h00;
    // fuse pin, sampled only, never written by the cpu
    nxt_s.fsync = {s_ff.fsync[1:0], boot_vector_fuse};
    if (s_ff.fsync[1] == s_ff.fsync[2]) begin
      nxt_s.fuse = s_ff.fsync[2];
    end
    nxt_s.vec = s_ff.fuse ? APP_RESET_ADDR : BOOT_RESET_ADDR;
    // register reads
    if (bus.rd) begin
      case (bus.addr)
        REG_CTRL: nxt_s.rd = s_ff.ctrl;
        REG_PTR_LO: nxt_s.rd = s_ff.ptr[7:0];
        REG_PTR_HI: nxt_s.rd = s_ff.ptr[15:8];
        REG_EXT_PAGE: nxt_s.rd = {7'h00, s_ff.ext};
        REG_DATA_LO: nxt_s.rd = s_ff.dlo;
        REG_DATA_HI: nxt_s.rd = s_ff.dhi;
        REG_LOCK: nxt_s.rd = LOCK_PAD | {2'h0, s_ff.lock, 2'h0};
        default: nxt_s.rd = UNMAPPED_RD;
      endcase
    end
    // register writes
    if (bus.wr) begin
      case (bus.addr)
        REG_CTRL: begin
          nxt_s.ctrl.ie = bus.wdata[7];
          if (s_ff.st != ST_BUSY && !eeprom_busy) begin
            nxt_s.ctrl.reenable = bus.wdata[4];
            nxt_s.ctrl.lock_set = bus.wdata[3];
            nxt_s.ctrl.write = bus.wdata[2];
            nxt_s.ctrl.erase = bus.wdata[1];
            nxt_s.ctrl.store_en = bus.wdata[0];
            if (bus.wdata[4]) begin
              nxt_s.ctrl.busy = 1'b0;
              buf_clr = 1'b1;
            end
            if (bus.wdata[0]) begin
              nxt_s.st = ST_ARMED;
              nxt_s.win = WINDOW_CYC;
            end
          end
        end
        REG_PTR_LO: nxt_s.ptr[7:0] = bus.wdata;
        REG_PTR_HI: nxt_s.ptr[15:8] = bus.wdata;
        REG_EXT_PAGE: nxt_s.ext = bus.wdata[0];
        REG_DATA_LO: nxt_s.dlo = bus.wdata;
        REG_DATA_HI: nxt_s.dhi = bus.wdata;
        default: nxt_s.rd = nxt_s.rd;
      endcase
    end
    // byte-wise program-memory load
    if (load_exec) begin
      nxt_s.ld = s_ff.ptr[0] ? flash_read_word[15:8] : flash_read_word[7:0];
    end
    // sequencer
    case (s_ff.st)
      ST_IDLE: begin
        nxt_s.st = nxt_s.st;
      end
      ST_ARMED: begin
        if (store_exec) begin
          nxt_s.ctrl[4:0] = 5'h00;
          nxt_s.st = ST_IDLE;
          if (s_ff.ctrl.lock_set && s_ff.ctrl[2:0] == 3'h1) begin
            nxt_s.lock = s_ff.lock & s_ff.dlo[5:2];
            nxt_s.lock_req = 1'b1;
            nxt_s.ctrl.store_en = 1'b1;
            nxt_s.op_halt = 1'b0;
            nxt_s.op_write = 1'b0;
            nxt_s.st = ST_BUSY;
          end else if (!s_ff.ctrl.lock_set && !s_ff.ctrl.reenable) begin
            case (s_ff.ctrl[2:0])
              CMD_LOAD: begin
                buf_wr = 1'b1;
                nxt_s.buf_used = 1'b1;
              end
              CMD_ERASE, CMD_WRITE: begin
                nxt_s.op_page = page_of(s_ff.ext, s_ff.ptr);
                nxt_s.op_write = s_ff.ctrl.write;
                nxt_s.erase_req = s_ff.ctrl.erase;
                nxt_s.write_req = s_ff.ctrl.write;
                nxt_s.op_halt = in_halt(page_of(s_ff.ext, s_ff.ptr));
                nxt_s.ctrl.busy = nxt_s.ctrl.busy | !in_halt(page_of(s_ff.ext, s_ff.ptr));
                nxt_s.ctrl.store_en = 1'b1;
                nxt_s.st = ST_BUSY;
              end
              default: nxt_s.st = ST_IDLE;
            endcase
          end
        end else if (s_ff.win == 3'h1) begin
          nxt_s.ctrl[4:0] = 5'h00;
          nxt_s.st = ST_IDLE;
        end else begin
          nxt_s.win = s_ff.win - 3'h1;
        end
      end
      ST_BUSY: begin
        if (flash_done) begin
          nxt_s.ctrl.store_en = 1'b0;
          nxt_s.op_halt = 1'b0;
          nxt_s.st = ST_IDLE;
          if (s_ff.op_write) begin
            buf_clr = 1'b1;
          end
        end
      end
      default: nxt_s.st = ST_IDLE;
    endcase
    if (eeprom_write && s_ff.buf_used) begin
      buf_clr = 1'b1;
    end
    if (buf_clr) begin
      nxt_s.buf_used = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff.st <= ST_IDLE;
      s_ff.ctrl <= CTRL_RST;
      s_ff.win <= 3'h0;
      s_ff.ptr <= 16'h0000;
      s_ff.ext <= 1'b0;
      s_ff.dlo <= 8'h00;
      s_ff.dhi <= 8'h00;
      s_ff.lock <= LOCK_RST;
      s_ff.op_page <= '0;
      s_ff.op_write <= 1'b0;
      s_ff.op_halt <= 1'b0;
      s_ff.erase_req <= 1'b0;
      s_ff.write_req <= 1'b0;
      s_ff.lock_req <= 1'b0;
      s_ff.buf_used <= 1'b0;
      s_ff.rd <= 8'h00;
      s_ff.ld <= 8'h00;
      s_ff.fsync <= 3'h7;
      s_ff.fuse <= 1'b1;
      s_ff.vec <= APP_RESET_ADDR;
    end else begin
      s_ff <= nxt_s;
    end
  end

  fsp_page_buffer u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .wr(buf_wr),
    .widx(s_ff.ptr[7:1]),
    .wdata({s_ff.dhi, s_ff.dlo}),
    .clr(buf_clr),
    .ridx(flash_buf_idx),
    .rdata(flash_buf_word)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rdata = s_ff.rd;
  assign reset_vector = s_ff.vec;
  assign cpu_halt = s_ff.op_halt;
  assign store_irq = s_ff.ctrl.ie & ~s_ff.ctrl.store_en;
  assign flash_erase_req = s_ff.erase_req;
  assign flash_write_req = s_ff.write_req;
  assign flash_lock_req = s_ff.lock_req;
  assign flash_page = s_ff.op_page;
  assign flash_read_addr = {s_ff.ext, s_ff.ptr[15:1]};
  assign load_data = s_ff.ld;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_vector;
    @(posedge clk) disable iff (!rst_n)
      $stable(s_ff.fuse) |=> (reset_vector == ($past(s_ff.fuse) ? APP_RESET_ADDR : BOOT_RESET_ADDR));
  endproperty
  a_vector: assert property (p_vector) else $error("reset vector mismatch");

  property p_latched;
    @(posedge clk) disable iff (!rst_n)
      (s_ff.st == ST_BUSY && !flash_done) |=> $stable(flash_page);
  endproperty
  a_latched: assert property (p_latched) else $error("page moved during op");

  property p_erase;
    @(posedge clk) disable iff (!rst_n)
      (s_ff.st == ST_ARMED && store_exec && s_ff.ctrl[4:0] == {2'h0, CMD_ERASE})
      |=> flash_erase_req && s_ff.st == ST_BUSY && flash_page == $past(page_of(s_ff.ext, s_ff.ptr));
  endproperty
  a_erase: assert property (p_erase) else $error("erase not started");

  property p_load;
    @(posedge clk) disable iff (!rst_n)
      (s_ff.st == ST_ARMED && store_exec && s_ff.ctrl[4:0] == {2'h0, CMD_LOAD} && !eeprom_write)
      |=> s_ff.buf_used && s_ff.st == ST_IDLE && store_irq == s_ff.ctrl.ie;
  endproperty
  a_load: assert property (p_load) else $error("load not taken");

  property p_window;
    @(posedge clk) disable iff (!rst_n)
      (bus.wr && bus.addr == REG_CTRL && bus.wdata[0] && s_ff.st == ST_IDLE && !eeprom_busy)
      ##1 (!store_exec) [*4] |=> (s_ff.ctrl[3:0] == 4'h0 && s_ff.st == ST_IDLE);
  endproperty
  a_window: assert property (p_window) else $error("window did not expire");

  property p_halt;
    @(posedge clk) disable iff (!rst_n)
      (flash_erase_req || flash_write_req) |-> (cpu_halt == in_halt(flash_page));
  endproperty
  a_halt: assert property (p_halt) else $error("halt does not match section");

  property p_busy_hold;
    @(posedge clk) disable iff (!rst_n)
      (s_ff.ctrl.busy && !(bus.wr && bus.addr == REG_CTRL)) |=> s_ff.ctrl.busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped");

  property p_wr_clear;
    @(posedge clk) disable iff (!rst_n)
      (s_ff.st == ST_BUSY && s_ff.op_write && flash_done) |=> !s_ff.buf_used && !cpu_halt;
  endproperty
  a_wr_clear: assert property (p_wr_clear) else $error("buffer kept after write");

  property p_eeprom;
    @(posedge clk) disable iff (!rst_n)
      (eeprom_write && s_ff.st != ST_ARMED) |=> !s_ff.buf_used;
  endproperty
  a_eeprom: assert property (p_eeprom) else $error("buffer kept after eeprom write");

  property p_irq;
    @(posedge clk) disable iff (!rst_n)
      (s_ff.st == ST_BUSY && flash_done && s_ff.ctrl.ie && !(bus.wr && bus.addr == REG_CTRL))
      |=> store_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("no irq after done");

  c_erase: cover property (@(posedge clk) disable iff (!rst_n) flash_erase_req);
  c_write: cover property (@(posedge clk) disable iff (!rst_n) flash_write_req && cpu_halt);
  c_lock: cover property (@(posedge clk) disable iff (!rst_n) flash_lock_req);
  c_expire: cover property (@(posedge clk) disable iff (!rst_n)
    s_ff.st == ST_ARMED ##1 s_ff.st == ST_IDLE);
endmodule

// ===== fsp_pkg.sv
package fsp_pkg;
  // ----------------------------------------
  // geometry
  // ----------------------------------------
  localparam int unsigned WORD_W = 7;
  localparam int unsigned PAGE_W = 9;
  localparam int unsigned PAGE_WORDS = 128;
  localparam logic [PAGE_W-1:0] HALT_FIRST_PAGE = 9'h1E0;
  // ----------------------------------------
  // register map and reset values
  // ----------------------------------------
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_PTR_LO = 3'h1;
  localparam logic [2:0] REG_PTR_HI = 3'h2;
  localparam logic [2:0] REG_EXT_PAGE = 3'h3;
  localparam logic [2:0] REG_DATA_LO = 3'h4;
  localparam logic [2:0] REG_DATA_HI = 3'h5;
  localparam logic [2:0] REG_LOCK = 3'h6;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] LOCK_RST = 4'hF;
  localparam logic [7:0] LOCK_PAD = 8'hC3;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
  // ----------------------------------------
  // command codes in ctrl bits 2:0 and timing
  // ----------------------------------------
  localparam logic [2:0] CMD_LOAD = 3'h1;
  localparam logic [2:0] CMD_ERASE = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h5;
  localparam logic [2:0] WINDOW_CYC = 3'h4;
  localparam logic [15:0] APP_RESET_ADDR = 16'h0000;
  localparam logic [15:0] BOOT_RESET_ADDR = 16'hF000;
  localparam logic [15:0] BUF_ERASED = 16'hFFFF;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic ie;
    logic busy;
    logic rsv;
    logic reenable;
    logic lock_set;
    logic write;
    logic erase;
    logic store_en;
  } fsp_ctrl_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fsp_bus_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_BUSY = 3'b100
  } fsp_state_t;
endpackage

// ===== fsp_page_buffer.sv
`timescale 1ns/1ps
module fsp_page_buffer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr,
  input wire logic [fsp_pkg::WORD_W-1:0] widx,
  input wire logic [15:0] wdata,
  input wire logic clr,
  input wire logic [fsp_pkg::WORD_W-1:0] ridx,
  output logic [15:0] rdata
);
  import fsp_pkg::*;

  typedef struct packed {
    logic [PAGE_WORDS-1:0][15:0] mem;
    logic [15:0] rd;
  } fsp_buf_state_t;

  fsp_buf_state_t s_ff;
  fsp_buf_state_t nxt_s;

  // ----------------------------------------
  // storage, any load order, clear on demand
  // ----------------------------------------
  always_comb begin
    nxt_s = s_ff;
    nxt_s.rd = s_ff.mem[ridx];
    if (clr) begin
      nxt_s.mem = {PAGE_WORDS{BUF_ERASED}};
    end else if (wr) begin
      nxt_s.mem[widx] = wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff.mem <= {PAGE_WORDS{BUF_ERASED}};
      s_ff.rd <= 16'h0000;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rdata = s_ff.rd;
endmodule

// ===== fsp_flash_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// flash array stand-in: one page image
// ----------------------------------------
module fsp_flash_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] lat,
  input wire logic flash_erase_req,
  input wire logic flash_write_req,
  input wire logic flash_lock_req,
  input wire logic [8:0] flash_page,
  output logic flash_done,
  output logic [6:0] flash_buf_idx,
  input wire logic [15:0] flash_buf_word,
  input wire logic [15:0] flash_read_addr,
  output logic [15:0] flash_read_word
);
  logic [15:0] img_ff [128];
  logic [8:0] page_ff;
  logic [7:0] cnt_ff;
  logic [7:0] k_ff;
  logic busy_ff;
  assign flash_buf_idx = k_ff[6:0];
  assign flash_read_word = (flash_read_addr[15:7] == page_ff) ?
    img_ff[flash_read_addr[6:0]] : 16'hFFFF;
  // buffer word shows one cycle after its index, so capture lags by one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_done <= 1'b0;
      busy_ff <= 1'b0;
      cnt_ff <= 8'h00;
      k_ff <= 8'hFF;
      page_ff <= 9'h1FF;
      for (int i = 0; i < 128; i++) img_ff[i] <= 16'hFFFF;
    end else begin
      flash_done <= 1'b0;
      if (flash_erase_req || flash_lock_req) begin
        busy_ff <= 1'b1;
        cnt_ff <= lat;
      end else if (flash_write_req) begin
        busy_ff <= 1'b1;
        cnt_ff <= lat;
        k_ff <= 8'h00;
        page_ff <= flash_page;
      end else if (k_ff <= 8'h80) begin
        if (k_ff != 8'h00) img_ff[k_ff[6:0] - 7'h01] <= flash_buf_word;
        k_ff <= k_ff + 8'h01;
      end else if (busy_ff) begin
        if (cnt_ff == 8'h00) begin
          flash_done <= 1'b1;
          busy_ff <= 1'b0;
        end else cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end
endmodule

// ===== flash_self_program_sequencer_tb.sv
`timescale 1ns/1ps
module flash_self_program_sequencer_tb;
  import fsp_pkg::*;
  logic clk;
  logic rst_n;
  fsp_bus_t bus;
  logic [7:0] rdata, load_data, lat;
  logic store_exec, load_exec, eeprom_write, eeprom_busy, boot_vector_fuse;
  logic cpu_halt, store_irq, flash_erase_req, flash_write_req, flash_lock_req, flash_done;
  logic [8:0] flash_page;
  logic [6:0] flash_buf_idx;
  logic [15:0] reset_vector, flash_buf_word, flash_read_addr, flash_read_word;
  int num_errors = 0;
  int num_checks = 0;
  fsp_sequencer dut_u (.clk, .rst_n, .bus, .rdata, .store_exec, .load_exec, .eeprom_write,
    .eeprom_busy, .boot_vector_fuse, .reset_vector, .cpu_halt, .store_irq, .flash_erase_req,
    .flash_write_req, .flash_lock_req, .flash_page, .flash_done, .flash_buf_idx,
    .flash_buf_word, .flash_read_addr, .flash_read_word, .load_data);
  fsp_flash_model fm_u (.clk, .rst_n, .lat, .flash_erase_req, .flash_write_req,
    .flash_lock_req, .flash_page, .flash_done, .flash_buf_idx, .flash_buf_word,
    .flash_read_addr, .flash_read_word);
  // ----------------------------------------
  // common tasks
  // ----------------------------------------
  task automatic test_done;
    if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] g, input logic [15:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input string m);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 cmp(16'(rdata), 16'(e), m);
  endtask
  task automatic spm;
    @(posedge clk);
    store_exec <= 1'b1;
    @(posedge clk);
    store_exec <= 1'b0;
  endtask
  task automatic wait_done;
    for (int n = 0; n < 2000 && flash_done !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (flash_done !== 1'b1) begin
      num_errors++;
      $display("MISMATCH %0t no flash done", $time);
      test_done;
    end
  endtask
  task automatic setp(input logic [8:0] pg, input logic [6:0] w, input logic b);
    wr(REG_PTR_LO, {w, b});
    wr(REG_PTR_HI, pg[7:0]);
    wr(REG_EXT_PAGE, {7'h00, pg[8]});
  endtask
  task automatic ldw(input logic [6:0] w, input logic [15:0] d);
    setp(9'h000, w, 1'b0);
    wr(REG_DATA_LO, d[7:0]);
    wr(REG_DATA_HI, d[15:8]);
    wr(REG_CTRL, {5'h00, CMD_LOAD});
    spm;
  endtask
  task automatic op(input logic [2:0] c, input logic [8:0] pg, input logic h);
    setp(pg, 7'h00, 1'b0);
    wr(REG_CTRL, {5'h00, c});
    spm;
    if (h) repeat (6) @(posedge clk);
    else setp(~pg, 7'h55, 1'b1);
    #1 cmp(16'(flash_page), 16'(pg), "page");
    cmp(16'(cpu_halt), 16'(h), "halt");
    wait_done;
  endtask
  task automatic lpm(input logic [6:0] w, input logic b, input logic [7:0] e);
    setp(9'h1E3, w, b);
    @(posedge clk);
    load_exec <= 1'b1;
    @(posedge clk);
    load_exec <= 1'b0;
    @(posedge clk);
    #1 cmp(16'(load_data), 16'(e), "load byte");
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_fuse;
    repeat (8) @(posedge clk);
    #1 cmp(reset_vector, APP_RESET_ADDR, "app vector");
    ldw(7'h02, 16'h2222);
    boot_vector_fuse <= 1'b0;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    #1 cmp(reset_vector, BOOT_RESET_ADDR, "boot vector");
    rd(REG_LOCK, 8'hFF, "lock reset");
    op(CMD_ERASE, 9'h040, 1'b0);
    op(CMD_WRITE, 9'h040, 1'b0);
    cmp(fm_u.img_ff[2], BUF_ERASED, "reset clears buffer");
    wr(REG_CTRL, 8'h10);
  endtask
  task automatic t_window;
    wr(REG_CTRL, 8'h80);
    #1 cmp(16'(store_irq), 16'h1, "irq idle");
    wr(REG_CTRL, 8'h81);
    #1 cmp(16'(store_irq), 16'h0, "irq armed");
    repeat (5) @(posedge clk);
    #1 cmp(16'(store_irq), 16'h1, "irq after expiry");
    rd(REG_CTRL, 8'h80, "ctrl after expiry");
    eeprom_busy <= 1'b1;
    wr(REG_CTRL, 8'h81);
    #1 cmp(16'(store_irq), 16'h1, "ctrl refused");
    eeprom_busy <= 1'b0;
    wr(REG_CTRL, 8'h00);
  endtask
  task automatic t_page;
    ldw(7'h05, 16'hA5C3);
    ldw(7'h7F, 16'h1234);
    ldw(7'h00, 16'hBEEF);
    op(CMD_ERASE, 9'h1E3, 1'b1);
    op(CMD_WRITE, 9'h1E3, 1'b1);
    cmp(fm_u.img_ff[5], 16'hA5C3, "word 5");
    cmp(fm_u.img_ff[127], 16'h1234, "word 127");
    cmp(fm_u.img_ff[0], 16'hBEEF, "word 0");
    cmp(fm_u.img_ff[1], BUF_ERASED, "word 1");
    lpm(7'h05, 1'b1, 8'hA5);
    lpm(7'h05, 1'b0, 8'hC3);
    op(CMD_ERASE, 9'h1E3, 1'b1);
    op(CMD_WRITE, 9'h1E3, 1'b1);
    cmp(fm_u.img_ff[5], BUF_ERASED, "write clears buffer");
  endtask
  task automatic t_busy;
    op(CMD_ERASE, 9'h010, 1'b0);
    rd(REG_CTRL, 8'h40, "busy after erase");
    ldw(7'h03, 16'h7777);
    rd(REG_CTRL, 8'h40, "busy kept");
    wr(REG_CTRL, 8'h10);
    rd(REG_CTRL, 8'h10, "busy cleared");
    op(CMD_WRITE, 9'h010, 1'b0);
    cmp(fm_u.img_ff[3], BUF_ERASED, "reenable clears buffer");
    wr(REG_CTRL, 8'h10);
  endtask
  task automatic t_eeprom;
    lat <= 8'd200;
    ldw(7'h09, 16'h9999);
    @(posedge clk);
    eeprom_write <= 1'b1;
    @(posedge clk);
    eeprom_write <= 1'b0;
    op(CMD_ERASE, 9'h030, 1'b0);
    op(CMD_WRITE, 9'h030, 1'b0);
    cmp(fm_u.img_ff[9], BUF_ERASED, "eeprom drops buffer");
    wr(REG_CTRL, 8'h10);
    lat <= 8'd3;
  endtask
  task automatic t_lock;
    setp(9'h1FF, 7'h7F, 1'b1);
    wr(REG_DATA_LO, 8'hE3);
    wr(REG_CTRL, 8'h09);
    spm;
    wait_done;
    rd(REG_LOCK, 8'hE3, "lock bits");
    rd(3'h7, 8'h00, "unmapped");
  endtask
  // ----------------------------------------
  // clock and main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    bus = '0;
    {store_exec, load_exec, eeprom_write, eeprom_busy} = 4'h0;
    boot_vector_fuse = 1'b1;
    lat = 8'd20;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_fuse;
    t_window;
    t_page;
    t_busy;
    t_eeprom;
    t_lock;
    cmp(reset_vector, BOOT_RESET_ADDR, "vector kept");
    test_done;
  end
endmodule
